//--- verilog/lpv_dev.sv
// Device end: serial receiver, the three configuration registers and their decoded controls.
module lpv_dev (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        pll_locked,
    input  wire logic [5:0]  cal_band,
    input  wire logic [6:0]  int_ratio,
    input  wire logic [11:0] frac_value,
    input  wire logic [11:0] frac_den,
    input  wire logic [15:0] pfd_mhz,
    output logic             low_power,
    output logic             mixer_high_current,
    output logic             lo_port_is_output,
    output logic             lo_driver_enable,
    output logic             external_lo_path_select,
    output logic             ext_lo_active,
    output logic [6:0]       ext_lo_div,
    output logic [5:0]       vco_band,
    output logic [4:0]       vco_amplitude,
    output logic             vco_enable,
    output logic             ldo_enable,
    output logic             cp_enable,
    output logic [3:0]       out_div_ratio,
    output logic [3:0]       lo_main_div,
    output logic             cal_restart,
    output logic [31:0]      f_vco_x2mod,
    lpv_if.dev               link
);
    // Link pins after their synchronisers.
    logic        sclk_s;
    logic        sdata_s;
    logic        sload_s;
    logic        lo_source_pin_s;
    // Receiver: last seen strobe levels, edge marks and the shift register.
    logic        sclk_p_q;
    logic        sclk_p_d;
    logic        sload_p_q;
    logic        sload_p_d;
    logic        sclk_rise;
    logic        sload_rise;
    logic [23:0] sh_q;
    logic [23:0] sh_d;
    // Register bank and the calibration restart pulse.
    logic [23:0] lp_q;
    logic [23:0] lp_d;
    logic [23:0] vc_q;
    logic [23:0] vc_d;
    logic [23:0] ld_q;
    logic [23:0] ld_d;
    logic        cal_q;
    logic        cal_d;
    // Decoded controls.
    logic        mhc_q;
    logic        mhc_d;
    logic [5:0]  band_q;
    logic [5:0]  band_d;
    logic [3:0]  odr_q;
    logic [3:0]  odr_d;
    logic [6:0]  xd_q;
    logic [6:0]  xd_d;
    logic        xa_q;
    logic        xa_d;
    // Status: lock indication and the scaled loop frequency.
    logic        mon_q;
    logic        mon_d;
    logic [31:0] fv_q;
    logic [31:0] fv_d;

    lpv_sync u_sclk  (.clk(clk), .rst(rst), .d(link.sclk),          .q(sclk_s));
    lpv_sync u_sdata (.clk(clk), .rst(rst), .d(link.sdata),         .q(sdata_s));
    lpv_sync u_sload (.clk(clk), .rst(rst), .d(link.sload),         .q(sload_s));
    lpv_sync u_lo_source_pin (.clk(clk), .rst(rst), .d(link.lo_source_pin), .q(lo_source_pin_s));

    // Receiver. The host moves data only while the serial clock is low, so with the same
    // synchroniser delay on both pins the data is settled at every detected rise.
    always_comb begin
        sclk_p_d   = sclk_s;
        sload_p_d  = sload_s;
        sclk_rise  = sclk_s && !sclk_p_q;
        sload_rise = sload_s && !sload_p_q;
        sh_d       = sh_q;
        if (sclk_rise) begin
            sh_d = {sh_q[22:0], sdata_s};
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_p_q  <= 1'b0;
            sload_p_q <= 1'b0;
            sh_q      <= 24'h000000;
        end else begin
            sclk_p_q  <= sclk_p_d;
            sload_p_q <= sload_p_d;
            sh_q      <= sh_d;
        end
    end

    // Register bank. A whole word lands at once on the load strobe, so a half-shifted
    // word never reaches the controls.
    always_comb begin
        lp_d  = lp_q;
        vc_d  = vc_q;
        ld_d  = ld_q;
        cal_d = 1'b0;
        if (sload_rise) begin
            case (sh_q[2:0])
                lpv_pkg::ADDR_LO_PATH: lp_d = sh_q;
                lpv_pkg::ADDR_VCO:     vc_d = sh_q;
                lpv_pkg::ADDR_LO_DIV:  ld_d = sh_q;
                default: begin
                    // Other registers live elsewhere; only the calibration restart is seen here.
                    cal_d = (sh_q[2:0] <= lpv_pkg::ADDR_CAL_MAX);
                end
            endcase
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lp_q  <= lpv_pkg::LO_PATH_RESET;
            vc_q  <= lpv_pkg::VCO_RESET;
            ld_q  <= lpv_pkg::LO_DIV_RESET;
            cal_q <= 1'b0;
        end else begin
            lp_q  <= lp_d;
            vc_q  <= vc_d;
            ld_q  <= ld_d;
            cal_q <= cal_d;
        end
    end

    // Decoded controls are registered so that every output leaves a flip-flop; the extra
    // cycle of latency is far below the spacing of two serial words.
    always_comb begin
        mhc_d = ~lp_q[lpv_pkg::LP_LOW_POWER];
        if (vc_q[lpv_pkg::VC_BAND_SRC]) begin
            band_d = vc_q[lpv_pkg::VC_BAND_LSB +: lpv_pkg::VC_BAND_W];
        end else begin
            band_d = cal_band;
        end
        case (ld_q[lpv_pkg::LD_OUT_LSB +: 2])
            lpv_pkg::OUTDIV_BY8: odr_d = lpv_pkg::RATIO_8;
            lpv_pkg::OUTDIV_BY6: odr_d = lpv_pkg::RATIO_6;
            default:             odr_d = lpv_pkg::RATIO_4;
        endcase
        // The external divide is clamped to the range that the mixer divider can serve.
        xd_d = lp_q[lpv_pkg::LP_EXTDIV_LSB +: lpv_pkg::LP_EXTDIV_W];
        if (xd_d < lpv_pkg::EXTDIV_MIN) begin
            xd_d = lpv_pkg::EXTDIV_MIN;
        end
        if (xd_d > lpv_pkg::EXTDIV_MAX) begin
            xd_d = lpv_pkg::EXTDIV_MAX;
        end
        xa_d = !lo_source_pin_s && !lp_q[lpv_pkg::LP_LO_DRV] && lp_q[lpv_pkg::LP_EXT_PATH];
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mhc_q  <= ~lpv_pkg::LO_PATH_RESET[lpv_pkg::LP_LOW_POWER];
            band_q <= 6'h00;
            odr_q  <= lpv_pkg::RATIO_4;
            xd_q   <= lpv_pkg::EXTDIV_MIN;
            xa_q   <= 1'b0;
        end else begin
            mhc_q  <= mhc_d;
            band_q <= band_d;
            odr_q  <= odr_d;
            xd_q   <= xd_d;
            xa_q   <= xa_d;
        end
    end

    // The frequency word is pfd * 2 * (int * den + frac); its reader divides by den, which
    // keeps a divider out of this logic. With the whole ratio kept to 119 it wraps only
    // above about 4370 MHz at the phase detector.
    always_comb begin
        mon_d = pll_locked;
        fv_d  = 32'(pfd_mhz) * 32'({int_ratio, 1'b0}) * 32'(frac_den)
              + 32'(pfd_mhz) * 32'({frac_value, 1'b0});
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mon_q <= 1'b0;
            fv_q  <= 32'h00000000;
        end else begin
            mon_q <= mon_d;
            fv_q  <= fv_d;
        end
    end

    assign low_power               = lp_q[lpv_pkg::LP_LOW_POWER];
    assign mixer_high_current      = mhc_q;
    assign lo_port_is_output       = lp_q[lpv_pkg::LP_LO_DIR];
    assign lo_driver_enable        = lp_q[lpv_pkg::LP_LO_DRV];
    assign external_lo_path_select = lp_q[lpv_pkg::LP_EXT_PATH];
    assign ext_lo_active           = xa_q;
    assign ext_lo_div              = xd_q;
    assign vco_band                = band_q;
    assign vco_amplitude           = vc_q[lpv_pkg::VC_AMP_LSB +: lpv_pkg::VC_AMP_W];
    assign vco_enable              = vc_q[lpv_pkg::VC_VCO_EN];
    assign ldo_enable              = vc_q[lpv_pkg::VC_LDO_EN];
    assign cp_enable               = vc_q[lpv_pkg::VC_CP_EN];
    assign out_div_ratio           = odr_q;
    assign lo_main_div             = ld_q[lpv_pkg::LD_MAIN_LSB +: lpv_pkg::LD_MAIN_W];
    assign cal_restart             = cal_q;
    assign f_vco_x2mod             = fv_q;
    assign link.monitor_output_pin = mon_q;
endmodule

//--- include/lpv_pkg.sv
// Package with register map, field positions and reset values of the LO path configuration.
package lpv_pkg;
    localparam int unsigned WORD_W        = 24;
    localparam int unsigned CTRL_W        = 3;
    localparam logic [2:0]  ADDR_LO_PATH  = 3'h5;
    localparam logic [2:0]  ADDR_VCO      = 3'h6;
    localparam logic [2:0]  ADDR_LO_DIV   = 3'h7;
    localparam logic [2:0]  ADDR_CAL_MAX  = 3'h2;
    // LO path and demodulator register fields.
    localparam int unsigned LP_LOW_POWER  = 5;
    localparam int unsigned LP_LO_DIR     = 6;
    localparam int unsigned LP_LO_DRV     = 7;
    localparam int unsigned LP_EXT_PATH   = 8;
    localparam int unsigned LP_EXTDIV_LSB = 9;
    localparam int unsigned LP_EXTDIV_W   = 7;
    // VCO control and enables register fields.
    localparam int unsigned VC_BAND_LSB   = 3;
    localparam int unsigned VC_BAND_W     = 6;
    localparam int unsigned VC_BAND_SRC   = 9;
    localparam int unsigned VC_AMP_LSB    = 10;
    localparam int unsigned VC_AMP_W      = 5;
    localparam int unsigned VC_VCO_EN     = 15;
    localparam int unsigned VC_LDO_EN     = 16;
    localparam int unsigned VC_CP_EN      = 17;
    // LO divider register fields.
    localparam int unsigned LD_OUT_LSB    = 4;
    localparam int unsigned LD_MAIN_LSB   = 6;
    localparam int unsigned LD_MAIN_W     = 4;
    localparam logic [1:0]  OUTDIV_BY8    = 2'h3;
    localparam logic [1:0]  OUTDIV_BY6    = 2'h2;
    localparam logic [1:0]  OUTDIV_BY4    = 2'h1;
    localparam logic [3:0]  RATIO_8       = 4'h8;
    localparam logic [3:0]  RATIO_6       = 4'h6;
    localparam logic [3:0]  RATIO_4       = 4'h4;
    localparam logic [6:0]  EXTDIV_MIN    = 7'h04;
    localparam logic [6:0]  EXTDIV_MAX    = 7'h50;
    localparam logic [4:0]  AMP_RESET     = 5'h18;
    localparam logic [23:0] LO_PATH_RESET = 24'h000805;
    localparam logic [23:0] VCO_RESET     = 24'h03e006;
    localparam logic [23:0] LO_DIV_RESET  = 24'h000017;
    localparam logic [6:0]  MAX_INT       = 7'h77;
    localparam int unsigned SCLK_DIV      = 6;
endpackage

//--- include/lpv_if.sv
// Interface carrying the three-wire serial programming link and the monitor pin.
interface lpv_if;
    logic sclk;
    logic sdata;
    logic sload;
    logic lo_source_pin;
    logic monitor_output_pin;
    modport host (output sclk, output sdata, output sload, output lo_source_pin,
                  input monitor_output_pin);
    modport dev  (input sclk, input sdata, input sload, input lo_source_pin,
                  output monitor_output_pin);
endinterface

//--- verilog/lpv_sync.sv
// Two-flip-flop synchroniser for a single pin.
module lpv_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic s1_q;
    logic s1_d;
    logic s2_q;
    logic s2_d;
    always_comb begin
        s1_d = d;
        s2_d = s1_q;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end
    assign q = s2_q;
endmodule

//--- verilog/lpv_host.sv
// Host end: shifts 24-bit words out MSB first on a divided clock, then pulses load.
module lpv_host #(
    parameter int unsigned DIV = lpv_pkg::SCLK_DIV
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wr_valid,
    input  wire logic [23:0] wr_word,
    input  wire logic        ext_lo_req,
    output logic             wr_ready,
    output logic             locked,
    lpv_if.host              link
);
    // The phase counter is eight bits wide, and one cycle per phase would leave no settle time.
    if (DIV < 2 || DIV > 256) begin : g_div_check
        $error("lpv_host: DIV must lie between 2 and 256");
    end
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b001,
        HS_SHIFT = 3'b010,
        HS_LOAD  = 3'b100
    } lpv_hstate_t;
    lpv_hstate_t st_q, st_d;
    logic [23:0] sh_q, sh_d;
    logic [4:0]  bit_q, bit_d;
    logic [7:0]  div_q, div_d;
    logic        sclk_q, sclk_d;
    logic        load_q, load_d;
    logic        rdy_q, rdy_d;
    logic        sel_q, sel_d;
    logic        lock_q, lock_d;
    logic        mon_s;
    lpv_sync u_mon (.clk(clk), .rst(rst), .d(link.monitor_output_pin), .q(mon_s));
    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        bit_d  = bit_q;
        div_d  = div_q;
        sclk_d = sclk_q;
        load_d = 1'b0;
        rdy_d  = 1'b0;
        sel_d  = ~ext_lo_req;
        lock_d = mon_s;
        case (st_q)
            HS_IDLE: begin
                rdy_d = 1'b1;
                if (wr_valid && rdy_q) begin
                    sh_d  = wr_word;
                    bit_d = 5'h00;
                    div_d = 8'h00;
                    rdy_d = 1'b0;
                    st_d  = HS_SHIFT;
                end
            end
            HS_SHIFT: begin
                if (div_q == 8'(DIV - 1)) begin
                    div_d = 8'h00;
                    if (sclk_q) begin
                        sclk_d = 1'b0;
                        sh_d   = {sh_q[22:0], 1'b0};
                        if (bit_q == 5'(lpv_pkg::WORD_W - 1)) begin
                            st_d = HS_LOAD;
                        end
                        bit_d = bit_q + 5'h01;
                    end else begin
                        sclk_d = 1'b1;
                    end
                end else begin
                    div_d = div_q + 8'h01;
                end
            end
            HS_LOAD: begin
                div_d = div_q + 8'h01;
                load_d = 1'b1;
                // The strobe stands for DIV whole cycles so that the far synchroniser sees it.
                if (div_q == 8'(DIV - 1)) begin
                    div_d  = 8'h00;
                    st_d   = HS_IDLE;
                end
            end
            default: st_d = HS_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q   <= HS_IDLE;
            sh_q   <= 24'h000000;
            bit_q  <= 5'h00;
            div_q  <= 8'h00;
            sclk_q <= 1'b0;
            load_q <= 1'b0;
            rdy_q  <= 1'b0;
            sel_q  <= 1'b1;
            lock_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            bit_q  <= bit_d;
            div_q  <= div_d;
            sclk_q <= sclk_d;
            load_q <= load_d;
            rdy_q  <= rdy_d;
            sel_q  <= sel_d;
            lock_q <= lock_d;
        end
    end
    assign link.sclk          = sclk_q;
    assign link.sdata         = sh_q[23];
    assign link.sload         = load_q;
    assign link.lo_source_pin = sel_q;
    assign wr_ready           = rdy_q;
    assign locked             = lock_q;
endmodule

//--- test/lpv_properties.sv
// Concurrent checks on the serial link between the host and device ends.
module lpv_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic sload
);
    logic       sclk_q, sclk_d;
    logic [4:0] rises_q, rises_d;
    // Rising serial clock edges are counted per frame; the load strobe clears the count.
    always_comb begin
        sclk_d = sclk;
        rises_d = sload ? 5'h0 : rises_q + 5'(sclk & ~sclk_q);
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            rises_q <= 5'h0;
        end else begin
            sclk_q <= sclk_d;
            rises_q <= rises_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_load_no_clock: assert property (sload |-> !sclk)
        else $error("serial clock high during load");
    chk_load_width: assert property ($rose(sload) |-> sload [*6] ##1 !sload)
        else $error("load strobe width wrong");
    chk_clock_high: assert property ($rose(sclk) |-> sclk [*6] ##1 !sclk)
        else $error("serial clock high phase wrong");
    chk_clock_low: assert property ($fell(sclk) && rises_q < 5'h18 |-> !sclk [*6] ##1 sclk)
        else $error("serial clock low phase wrong");
    chk_data_steady: assert property (sclk && $past(sclk) |-> $stable(sdata))
        else $error("data moved while clock high");
    chk_word_length: assert property ($rose(sload) |-> rises_q == 5'h18)
        else $error("frame not 24 bits");
    chk_no_extra_bit: assert property ($rose(sclk) |-> rises_q < 5'h18)
        else $error("clock edge beyond 24 bits");
    chk_rest_after_load: assert property ($fell(sload) |-> !sclk [*2])
        else $error("clock too soon after load");
endmodule

//--- test/tb.sv
// Bench: host and device ends joined by the link, random register traffic checked.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [27:0] LIMS = {7'h03, 7'h04, 7'h50, 7'h51};
    logic        clk, rst, wr_valid, ext_lo_req, pll_locked, wr_ready, locked;
    logic        lp, mhc, dir, drv, xps, xla, vce, lde, cpe, calr;
    logic [23:0] wr_word;
    logic [23:0] q[$];
    logic [11:0] fval, fden;
    logic [15:0] pfd;
    logic [6:0]  iratio, xdiv;
    logic [5:0]  cband, band;
    logic [4:0]  amp;
    logic [3:0]  odr, mdr;
    logic [31:0] fv;
    int          n_errors, comparisons, ncal, ecal;
    lpv_if link ();
    lpv_host lpv_host_inst (.clk(clk), .rst(rst), .wr_valid(wr_valid), .wr_word(wr_word),
        .ext_lo_req(ext_lo_req), .wr_ready(wr_ready), .locked(locked), .link(link));
    lpv_dev lpv_dev_inst (.clk(clk), .rst(rst), .pll_locked(pll_locked), .cal_band(cband),
        .int_ratio(iratio), .frac_value(fval), .frac_den(fden), .pfd_mhz(pfd), .low_power(lp),
        .mixer_high_current(mhc), .lo_port_is_output(dir), .lo_driver_enable(drv),
        .external_lo_path_select(xps), .ext_lo_active(xla), .ext_lo_div(xdiv),
        .vco_band(band), .vco_amplitude(amp), .vco_enable(vce), .ldo_enable(lde),
        .cp_enable(cpe), .out_div_ratio(odr), .lo_main_div(mdr), .cal_restart(calr),
        .f_vco_x2mod(fv), .link(link));
    lpv_properties lpv_properties_inst (.clk(clk), .rst(rst), .sclk(link.sclk),
        .sdata(link.sdata), .sload(link.sload));
    always #5 clk = ~clk;
    always @(posedge clk) if (calr === 1'b1) ncal++;
    task automatic cmp(input logic [31:0] a, input logic [31:0] e);
        comparisons++;
        if (a !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, a, e);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // The note is queued before the word leaves, so the checker never finds the queue short.
    task automatic put(input logic [23:0] w);
        q.push_back(w);
        wr_word = w;
        wr_valid = 1'b1;
        do @(posedge clk); while (wr_ready !== 1'b1);
        #1 wr_valid = 1'b0;
        do @(posedge clk); while (wr_ready !== 1'b1);
        #1;
    endtask
    task automatic chk(input logic [23:0] w);
        logic [6:0] e;
        e = w[15:9];
        if (e < lpv_pkg::EXTDIV_MIN) e = lpv_pkg::EXTDIV_MIN;
        if (e > lpv_pkg::EXTDIV_MAX) e = lpv_pkg::EXTDIV_MAX;
        if (w[2:0] <= 3'h2) ecal++;
        cmp(ncal, ecal);
        case (w[2:0])
            3'h5: begin
                cmp(lp, w[5]);
                cmp(mhc, !w[5]);
                cmp({drv, dir}, w[7:6]);
                cmp(xps, w[8]);
                cmp(xdiv, e);
            end
            3'h6: begin
                cmp(band, w[9] ? w[8:3] : cband);
                cmp(amp, w[14:10]);
                cmp({cpe, lde, vce}, w[17:15]);
            end
            3'h7: begin
                cmp(odr, w[5:4] == 2'h3 ? 4'h8 : w[5:4] == 2'h2 ? 4'h6 : 4'h4);
                cmp(mdr, w[9:6]);
            end
            default: ;
        endcase
    endtask
    // The register settles a few cycles after the strobe rises, before it drops, well ahead of this wait.
    always @(negedge link.sload) begin
        if (q.size() > 0) begin
            repeat (5) @(posedge clk);
            chk(q.pop_front());
        end
    end
    initial begin
        #800000;
        n_errors++;
        test_done();
    end
    initial begin
        logic [23:0] w;
        void'($urandom(32'h95f3));
        clk = 1'b0;
        rst = 1'b1;
        wr_valid = 1'b0;
        wr_word = 24'h0;
        ext_lo_req = 1'b0;
        pll_locked = 1'b0;
        cband = 6'($urandom);
        iratio = lpv_pkg::MAX_INT;
        fden = 12'($urandom) | 12'h001;
        fval = 12'($urandom % fden);
        pfd = 16'h0019;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk);
        #1 cmp(amp, lpv_pkg::AMP_RESET);
        cmp({cpe, lde, vce}, 3'h7);
        cmp(odr, 4'h4);
        cmp(mhc, 1'b1);
        for (int r = 0; r < 3; r++)
            for (int i = 7; i >= 0; i--) begin
                w = {21'($urandom), 3'(i)};
                if (i == 7) w[23:6] = 18'h0;
                put(w);
            end
        for (int i = 0; i < 4; i++) put({18'h0, 2'(i), 4'h7});
        for (int i = 0; i < 4; i++) put({8'h0, LIMS[i*7 +: 7], 6'h0, 3'h5});
        put(24'h000105);
        ext_lo_req = 1'b1;
        repeat (8) @(posedge clk);
        #1 cmp(xla, 1'b1);
        ext_lo_req = 1'b0;
        repeat (8) @(posedge clk);
        #1 cmp(xla, 1'b0);
        pll_locked = 1'b1;
        repeat (8) @(posedge clk);
        #1 cmp(locked, 1'b1);
        pll_locked = 1'b0;
        repeat (8) @(posedge clk);
        #1 cmp(locked, 1'b0);
        cmp(fv, 32'(pfd) * 2 * (32'(iratio) * 32'(fden) + 32'(fval)));
        test_done();
    end
endmodule
